/* src/pdosq_defines.svh */
// constants for the receive process-data frame decoder
// assumes the frame arrives as 64 bits, byte 0 in bits 7:0
`ifndef PDOSQ_DEFINES_SVH
`define PDOSQ_DEFINES_SVH

`define PDOSQ_RIN_LSB        0
`define PDOSQ_RIN_W          8
`define PDOSQ_SEL_W          7
`define PDOSQ_START_BIT      8
`define PDOSQ_MOVE_POS_BIT   9
`define PDOSQ_MOVE_NEG_BIT   10
`define PDOSQ_HOME_BIT       11
`define PDOSQ_ABORT_BIT      12
`define PDOSQ_CURRENT_BIT    13
`define PDOSQ_FREE_BIT       14
`define PDOSQ_CMD_LSB        16
`define PDOSQ_CMD_W          14
`define PDOSQ_HANDSHAKE_TRIGGER_BIT       30
`define PDOSQ_ARG_LSB        32
`define PDOSQ_ARG_W          32
`define PDOSQ_RUN_CODE       14'h1c05
`define PDOSQ_SEQ_MAX        32'h0000_0063
`define PDOSQ_FUNC_W         4
`define PDOSQ_FUNC_N         16
`define PDOSQ_FUNC_GENERAL   4'h0
`define PDOSQ_RST_FRAME      64'h0000_0000_0000_0000

`endif

/* src/pdosq_pkg.sv */
// types shared by the frame decoder modules
// assumes pdosq_defines.svh is on the include path
`include "pdosq_defines.svh"
package pdosq_pkg;
   typedef logic [`PDOSQ_CMD_W-1:0] pdosq_cmd_t;
   typedef logic [`PDOSQ_ARG_W-1:0] pdosq_arg_t;
   typedef logic [`PDOSQ_SEL_W-1:0] pdosq_seq_t;
   typedef enum logic [1:0] {
      PDOSQ_HS_IDLE = 2'b00,
      PDOSQ_HS_BUSY = 2'b01
   } pdosq_hs_state_t;
endpackage : pdosq_pkg

/* src/pdosq_frame_if.sv */
// latched frame fields passed from the frame latch to the decoder core
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface pdosq_frame_if;
   logic                  new_frame;
   logic [7:0]            rin;
   logic                  start;
   logic                  start_prev;
   logic                  move_pos;
   logic                  move_neg;
   logic                  home;
   logic                  abort;
   logic                  current;
   logic                  free;
   logic                  handshake_trigger;
   pdosq_pkg::pdosq_cmd_t cmd;
   pdosq_pkg::pdosq_arg_t arg;
   modport latch (output new_frame, rin, start, start_prev, move_pos, move_neg, home,
                  output abort, current, free, handshake_trigger, cmd, arg);
   modport core  (input new_frame, rin, start, start_prev, move_pos, move_neg, home,
                  input abort, current, free, handshake_trigger, cmd, arg);
endinterface : pdosq_frame_if

/* src/pdosq_frame_latch.sv */
// captures each received frame and the previous start bit
// assumes i_valid is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
`include "pdosq_defines.svh"
module pdosq_frame_latch (
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire logic        i_valid,
   input  wire logic [63:0] i_frame,
   pdosq_frame_if.latch     fr
);
   logic [63:0] frame_q;
   logic        new_q;
   logic        start_prev_q;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         frame_q      <= `PDOSQ_RST_FRAME;
         new_q        <= 1'b0;
         start_prev_q <= 1'b0;
      end else begin
         new_q <= i_valid;
         if (i_valid) begin
            start_prev_q <= frame_q[`PDOSQ_START_BIT];
            frame_q      <= i_frame;
         end
      end
   end

   assign fr.new_frame  = new_q;
   assign fr.rin        = frame_q[`PDOSQ_RIN_LSB +: `PDOSQ_RIN_W];
   assign fr.start      = frame_q[`PDOSQ_START_BIT];
   assign fr.start_prev = start_prev_q;
   assign fr.move_pos   = frame_q[`PDOSQ_MOVE_POS_BIT];
   assign fr.move_neg   = frame_q[`PDOSQ_MOVE_NEG_BIT];
   assign fr.home       = frame_q[`PDOSQ_HOME_BIT];
   assign fr.abort      = frame_q[`PDOSQ_ABORT_BIT];
   assign fr.current    = frame_q[`PDOSQ_CURRENT_BIT];
   assign fr.free       = frame_q[`PDOSQ_FREE_BIT];
   assign fr.handshake_trigger       = frame_q[`PDOSQ_HANDSHAKE_TRIGGER_BIT];
   assign fr.cmd        = frame_q[`PDOSQ_CMD_LSB +: `PDOSQ_CMD_W];
   assign fr.arg        = frame_q[`PDOSQ_ARG_LSB +: `PDOSQ_ARG_W];
endmodule : pdosq_frame_latch

/* src/pdosq_rin_map.sv */
// splits remote inputs into general inputs and system functions
// assumes the function assignment is quasi-static configuration
`timescale 1ns/1ps
`include "pdosq_defines.svh"
module pdosq_rin_map (
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire logic [7:0]  i_rin,
   input  wire logic [31:0] i_func,
   output logic      [7:0]  o_general,
   output logic      [15:0] o_sys_func
);
   logic [15:0] acc [0:8];
   logic [7:0]  assigned;

   assign acc[0] = 16'h0000;

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_in
         logic [3:0]  code;
         logic [15:0] hot;
         assign code        = i_func[g*4 +: 4];
         assign assigned[g] = (code != `PDOSQ_FUNC_GENERAL);
         assign o_general[g] = i_rin[g] & ~assigned[g];
         assign hot         = (assigned[g] && i_rin[g]) ? (16'h0001 << code) : 16'h0000;
         assign acc[g+1]    = acc[g] | hot;
         a_func_masks: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
            (i_func[g*4 +: 4] != 4'h0) |-> !o_general[g]) else $error("assigned input selects");
      end
   endgenerate

   assign o_sys_func = acc[8];

   a_assigned_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (o_general & assigned) == 8'h00) else $error("assigned input leaks to selection");
endmodule : pdosq_rin_map

/* src/pdosq_core.sv */
// How it works
// - the start bit starts a sequence only on its 0 to 1 change
// - the start bit takes the sequence number from inputs 0 to 6, 0 to 99
// - start-action setting: start bit zero does nothing, or aborts the running sequence
// - inputs assigned to system functions read zero and never select programs
// - trigger rising runs the program named in a run-sequence message's data
// - each remote input maps to one system function or acts as general
// - positive continuous-move bit at 1 starts positive continuous motion
// - negative continuous-move bit at 1 starts negative continuous motion
// - go-home bit at 1 starts homing of the configured homing type
// - abort bit at 1 stops all motion and aborts the running sequence
// - motor-current bit turns motor current off at 0, on at 1
// - shaft-free bit cuts current and releases the brake
// - command field selects parameter, monitor or maintenance action with data argument
//
// top of the receive frame decoder: latch, input map and the decision logic
// assumes frames come from bus logic on i_mclk, one-cycle i_rpdo_valid per frame
`timescale 1ns/1ps
`include "pdosq_defines.svh"
module pdosq_core (
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire logic        i_rpdo_valid,
   input  wire logic [63:0] i_rpdo_frame,
   input  wire logic        i_start_action,
   input  wire logic [3:0]  i_homing_type,
   input  wire logic [31:0] i_rin_func,
   input  wire logic        i_seq_done,
   output logic             o_seq_start,
   output logic      [6:0]  o_seq_number,
   output logic             o_seq_by_message,
   output logic             o_seq_reject,
   output logic             o_seq_running,
   output logic             o_seq_abort,
   output logic             o_move_pos,
   output logic             o_move_neg,
   output logic             o_home_request,
   output logic      [3:0]  o_homing_type,
   output logic             o_motion_stop,
   output logic             o_motor_current_on,
   output logic             o_brake_release,
   output logic             o_cmd_strobe,
   output logic      [13:0] o_cmd_code,
   output logic      [31:0] o_cmd_arg,
   output logic             o_handshake_trigger_echo,
   output logic      [7:0]  o_general_inputs,
   output logic      [15:0] o_sys_func
);
   pdosq_frame_if fr ();

   logic [7:0]                 general;
   logic [15:0]                sys_func;
   pdosq_pkg::pdosq_hs_state_t hs_q;
   pdosq_pkg::pdosq_hs_state_t hs_d;

   pdosq_frame_latch u_latch (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_valid (i_rpdo_valid),
      .i_frame (i_rpdo_frame),
      .fr      (fr)
   );

   pdosq_rin_map u_map (
      .i_mclk     (i_mclk),
      .i_rst_n    (i_rst_n),
      .i_rin      (fr.rin),
      .i_func     (i_rin_func),
      .o_general  (general),
      .o_sys_func (sys_func)
   );

   // decoding of the latched frame
   logic                  start_rise;
   logic                  start_low;
   logic                  handshake_trigger_rise;
   logic                  is_run;
   logic                  run_msg;
   logic                  abort_bit;
   logic                  abort_seq;
   logic                  go;
   logic                  num_ok;
   logic                  rin_ok;
   logic                  msg_ok;
   pdosq_pkg::pdosq_seq_t rin_num;
   pdosq_pkg::pdosq_seq_t msg_num;
   pdosq_pkg::pdosq_seq_t num;

   assign start_rise = fr.new_frame & fr.start & ~fr.start_prev;
   assign start_low  = fr.new_frame & ~fr.start;
   // acting on the first frame with trigger high makes a held trigger harmless
   assign handshake_trigger_rise  = fr.new_frame & fr.handshake_trigger & (hs_q == pdosq_pkg::PDOSQ_HS_IDLE);
   assign is_run     = (fr.cmd == `PDOSQ_RUN_CODE);
   assign run_msg    = handshake_trigger_rise & is_run;
   assign abort_bit  = fr.new_frame & fr.abort;
   assign abort_seq  = abort_bit | (start_low & i_start_action);
   assign rin_num    = general[`PDOSQ_SEL_W-1:0];
   assign msg_num    = fr.arg[`PDOSQ_SEL_W-1:0];
   assign rin_ok     = ({25'h0000000, rin_num} <= `PDOSQ_SEQ_MAX);
   assign msg_ok     = (fr.arg <= `PDOSQ_SEQ_MAX);
   // the input edge wins when both start paths fire in one frame
   assign go         = ~abort_bit & (start_rise | run_msg);
   assign num        = start_rise ? rin_num : msg_num;
   assign num_ok     = start_rise ? rin_ok : msg_ok;

   // handshake trigger: one action per 0 to 1 change
   always_comb begin
      hs_d = hs_q;
      case (hs_q)
         pdosq_pkg::PDOSQ_HS_IDLE: begin
            if (fr.new_frame && fr.handshake_trigger) begin
               hs_d = pdosq_pkg::PDOSQ_HS_BUSY;
            end
         end
         pdosq_pkg::PDOSQ_HS_BUSY: begin
            if (fr.new_frame && !fr.handshake_trigger) begin
               hs_d = pdosq_pkg::PDOSQ_HS_IDLE;
            end
         end
         default: begin
            hs_d = pdosq_pkg::PDOSQ_HS_IDLE;
         end
      endcase
   end

   logic seq_start_d;
   logic reject_d;
   logic running_d;
   logic running_q;
   logic cmd_strobe_d;
   logic move_pos_d;
   logic move_neg_d;

   assign seq_start_d  = go & num_ok;
   assign reject_d     = go & ~num_ok;
   // a start in the same cycle as done or abort keeps the sequence running
   assign running_d    = seq_start_d | (running_q & ~abort_seq & ~i_seq_done);
   assign cmd_strobe_d = handshake_trigger_rise & ~is_run;
   // opposite directions together would fight, so neither is granted
   assign move_pos_d   = fr.move_pos & ~fr.move_neg & ~fr.abort;
   assign move_neg_d   = fr.move_neg & ~fr.move_pos & ~fr.abort;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         hs_q             <= pdosq_pkg::PDOSQ_HS_IDLE;
         o_seq_start      <= 1'b0;
         o_seq_number     <= 7'h00;
         o_seq_by_message <= 1'b0;
         o_seq_reject     <= 1'b0;
         running_q        <= 1'b0;
         o_seq_abort      <= 1'b0;
         o_cmd_strobe     <= 1'b0;
      end else begin
         hs_q         <= hs_d;
         o_seq_start  <= seq_start_d;
         o_seq_reject <= reject_d;
         running_q    <= running_d;
         o_seq_abort  <= abort_seq;
         o_cmd_strobe <= cmd_strobe_d;
         if (go) begin
            o_seq_number     <= num;
            o_seq_by_message <= ~start_rise;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_cmd_code <= 14'h0000;
         o_cmd_arg  <= 32'h0000_0000;
      end else if (handshake_trigger_rise) begin
         o_cmd_code <= fr.cmd;
         o_cmd_arg  <= fr.arg;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_move_pos         <= 1'b0;
         o_move_neg         <= 1'b0;
         o_home_request     <= 1'b0;
         o_homing_type      <= 4'h0;
         o_motion_stop      <= 1'b0;
         o_motor_current_on <= 1'b0;
         o_brake_release    <= 1'b0;
         o_handshake_trigger_echo        <= 1'b0;
      end else if (fr.new_frame) begin
         o_move_pos         <= move_pos_d;
         o_move_neg         <= move_neg_d;
         o_home_request     <= fr.home & ~fr.abort;
         o_homing_type      <= i_homing_type;
         o_motion_stop      <= fr.abort;
         o_motor_current_on <= fr.current & ~fr.free;
         o_brake_release    <= fr.free;
         o_handshake_trigger_echo        <= fr.handshake_trigger;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_general_inputs <= 8'h00;
         o_sys_func       <= 16'h0000;
      end else begin
         o_general_inputs <= general;
         o_sys_func       <= sys_func;
      end
   end

   assign o_seq_running = running_q;

   // checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_start_held;
      fr.new_frame && fr.start && fr.start_prev && !handshake_trigger_rise;
   endsequence

   sequence s_rin_start;
      start_rise && !abort_bit && rin_ok;
   endsequence

   sequence s_msg_start;
      handshake_trigger_rise && is_run && msg_ok && !abort_bit && !start_rise;
   endsequence

   sequence s_handshake_trigger_held;
      hs_q == pdosq_pkg::PDOSQ_HS_BUSY && fr.new_frame && fr.handshake_trigger;
   endsequence

   a_start_level_ignored: assert property (s_start_held |=> !o_seq_start)
      else $error("held start bit restarted a sequence");

   // a run message in the very next frame may pulse again, which is legal
   a_start_takes_rin: assert property (s_rin_start |=>
      o_seq_start && !o_seq_by_message && o_seq_number == $past(rin_num) ##1
      (!o_seq_start || $past(run_msg)))
      else $error("input start lost or wrong number");

   a_zero_aborts: assert property ((start_low && i_start_action) |=> o_seq_abort)
      else $error("start bit zero did not abort");

   a_zero_idle: assert property ((start_low && !i_start_action && !fr.abort) |=>
      !o_seq_abort) else $error("start bit zero aborted with setting 0");

   a_msg_runs_seq: assert property (s_msg_start |=>
      o_seq_start && o_seq_by_message && o_seq_number == $past(msg_num) && !o_cmd_strobe)
      else $error("run message did not start its sequence");

   // a start-bit edge may still fire while the trigger is held
   a_handshake_trigger_held_once: assert property (s_handshake_trigger_held |=>
      !o_cmd_strobe && !(o_seq_start && o_seq_by_message))
      else $error("held trigger acted twice");

   a_move_positive: assert property ((fr.new_frame && fr.move_pos && !fr.move_neg &&
      !fr.abort) |=> o_move_pos && !o_move_neg) else $error("positive move not granted");

   a_move_negative: assert property ((fr.new_frame && fr.move_neg && !fr.move_pos &&
      !fr.abort) |=> o_move_neg && !o_move_pos) else $error("negative move not granted");

   a_home_type: assert property ((fr.new_frame && fr.home && !fr.abort) |=>
      o_home_request && o_homing_type == $past(i_homing_type))
      else $error("homing request or type wrong");

   a_abort_stops: assert property (abort_bit |=>
      o_motion_stop && !o_move_pos && !o_move_neg && !o_seq_running && !o_seq_start)
      else $error("abort left motion or sequence active");

   a_current_free: assert property (fr.new_frame |=>
      o_motor_current_on == ($past(fr.current) && !$past(fr.free)) &&
      o_brake_release == $past(fr.free)) else $error("current or brake state wrong");

   a_cmd_forward: assert property ((handshake_trigger_rise && !is_run) |=>
      o_cmd_strobe && o_cmd_code == $past(fr.cmd) && o_cmd_arg == $past(fr.arg))
      else $error("command not forwarded");

   a_bad_number: assert property ((go && !num_ok) |=> o_seq_reject && !o_seq_start)
      else $error("out of range number not refused");

   a_start_reject_excl: assert property (!(o_seq_start && o_seq_reject))
      else $error("start and reject in one cycle");

   // a held trigger must be let go before the handshake rearms
   a_handshake_trigger_rearm: assert property ((hs_q == pdosq_pkg::PDOSQ_HS_BUSY && fr.new_frame &&
      !fr.handshake_trigger) |=> hs_q == pdosq_pkg::PDOSQ_HS_IDLE)
      else $error("trigger low did not rearm");

   a_handshake_trigger_echo: assert property (fr.new_frame |=> o_handshake_trigger_echo == $past(fr.handshake_trigger))
      else $error("trigger echo wrong");

   // number and source are held between attempts so the executor can read them late
   a_number_held: assert property (!go |=>
      $stable(o_seq_number) && $stable(o_seq_by_message))
      else $error("sequence number changed without an attempt");

   a_running_holds: assert property ((o_seq_running && !abort_seq && !i_seq_done) |=>
      o_seq_running) else $error("sequence dropped without done or abort");

   a_move_exclusive: assert property (!(o_move_pos && o_move_neg))
      else $error("both move directions granted");

   a_sys_func_zero: assert property (o_sys_func[0] == 1'b0)
      else $error("general code reported as a system function");
endmodule : pdosq_core

/* verif/pdosq_master_model.sv */
// behavioural fieldbus master that sends receive frames to the decoder
// assumes the decoder samples a frame at the edge after o_valid rises
`timescale 1ns/1ps
module pdosq_master_model (
   input  wire logic        i_mclk,
   output logic             o_valid,
   output logic      [63:0] o_frame
);
   initial begin
      o_valid = 1'b0;
      o_frame = 64'h0000_0000_0000_0000;
   end

   // one frame per call; the bench repeats a start or trigger bit only on purpose
   task automatic send(input logic [7:0] rin, input logic [6:0] ctl, input logic [13:0] cmd,
                       input logic handshake_trigger, input logic [31:0] arg);
      logic [63:0] f;
      f = {arg, 1'b0, handshake_trigger, cmd, 1'b0, ctl, rin};
      @(posedge i_mclk);
      o_valid <= 1'b1;
      o_frame <= f;
      @(posedge i_mclk);
      o_valid <= 1'b0;
      // frame means nothing outside the strobe, so show junk rather than the last value
      o_frame <= ~f;
   endtask : send
endmodule : pdosq_master_model

/* verif/pdosq_core_tb_top.sv */
// self-checking bench for the receive frame decoder
// assumes the frame outputs settle one edge after the strobed edge
`timescale 1ns/1ps
module pdosq_core_tb_top;
   logic        i_mclk, i_rst_n, i_rpdo_valid, i_start_action, i_seq_done;
   logic [63:0] i_rpdo_frame;
   logic [3:0]  i_homing_type, o_homing_type;
   logic [31:0] i_rin_func, o_cmd_arg;
   logic        o_seq_start, o_seq_by_message, o_seq_reject, o_seq_running, o_seq_abort;
   logic        o_move_pos, o_move_neg, o_home_request, o_motion_stop, o_motor_current_on;
   logic        o_brake_release, o_cmd_strobe, o_handshake_trigger_echo;
   logic [6:0]  o_seq_number;
   logic [13:0] o_cmd_code;
   logic [7:0]  o_general_inputs;
   logic [15:0] o_sys_func;
   int          n_errors, checks_done;
   logic [6:0]  mv_ctl [8] = '{7'h02, 7'h04, 7'h06, 7'h08, 7'h18, 7'h20, 7'h60, 7'h12};
   logic [5:0]  mv_exp [8] = '{6'h01, 6'h02, 6'h00, 6'h04, 6'h08, 6'h10, 6'h20, 6'h08};
   logic [7:0]  sel_rin [4] = '{8'h00, 8'he3, 8'h64, 8'h7f};

   pdosq_master_model pdosq_master_model_i (.i_mclk(i_mclk), .o_valid(i_rpdo_valid),
                                            .o_frame(i_rpdo_frame));
   pdosq_core pdosq_core_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_rpdo_valid(i_rpdo_valid),
      .i_rpdo_frame(i_rpdo_frame), .i_start_action(i_start_action),
      .i_homing_type(i_homing_type), .i_rin_func(i_rin_func), .i_seq_done(i_seq_done),
      .o_seq_start(o_seq_start), .o_seq_number(o_seq_number),
      .o_seq_by_message(o_seq_by_message), .o_seq_reject(o_seq_reject),
      .o_seq_running(o_seq_running), .o_seq_abort(o_seq_abort), .o_move_pos(o_move_pos),
      .o_move_neg(o_move_neg), .o_home_request(o_home_request),
      .o_homing_type(o_homing_type), .o_motion_stop(o_motion_stop),
      .o_motor_current_on(o_motor_current_on), .o_brake_release(o_brake_release),
      .o_cmd_strobe(o_cmd_strobe), .o_cmd_code(o_cmd_code), .o_cmd_arg(o_cmd_arg),
      .o_handshake_trigger_echo(o_handshake_trigger_echo), .o_general_inputs(o_general_inputs),
      .o_sys_func(o_sys_func));

   always #20 i_mclk = ~i_mclk;

   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // send one frame, then wait until its outputs are visible
   task automatic frame(input logic [7:0] rin, input logic [6:0] ctl, input logic [13:0] cmd,
                        input logic handshake_trigger, input logic [31:0] arg);
      pdosq_master_model_i.send(rin, ctl, cmd, handshake_trigger, arg);
      @(posedge i_mclk);
      #1;
   endtask : frame

   task automatic seq_chk(input logic st, input logic [6:0] num, input logic msg,
                          input logic rej);
      chk(o_seq_start, st, "seq start");
      if (st === 1'b1 || rej === 1'b1) begin
         chk(o_seq_number, num, "seq number");
      end
      if (st === 1'b1) begin
         chk(o_seq_by_message, msg, "seq source");
      end
      chk(o_seq_reject, rej, "seq reject");
   endtask : seq_chk

   initial begin
      i_mclk = 1'b0;
      i_rst_n = 1'b0;
      i_start_action = 1'b0;
      i_seq_done = 1'b0;
      i_homing_type = 4'h0;
      i_rin_func = 32'h0000_0000;
      repeat (20) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(posedge i_mclk);
      #1;
      chk(o_seq_running, 1'b0, "reset running");
      frame(8'h03, 7'h01, 14'h0000, 1'b0, 32'h0); // start from a zero start bit
      seq_chk(1'b1, 7'h03, 1'b0, 1'b0);
      chk(o_seq_running, 1'b1, "running");
      frame(8'h03, 7'h01, 14'h0000, 1'b0, 32'h0);
      seq_chk(1'b0, 7'h03, 1'b0, 1'b0);
      frame(8'h03, 7'h00, 14'h0000, 1'b0, 32'h0);
      chk(o_seq_abort, 1'b0, "zero start no abort");
      @(posedge i_mclk);
      i_seq_done <= 1'b1;
      @(posedge i_mclk);
      i_seq_done <= 1'b0;
      repeat (2) @(posedge i_mclk);
      #1;
      chk(o_seq_running, 1'b0, "done clears running");
      @(posedge i_mclk);
      i_start_action <= 1'b1;
      frame(8'h00, 7'h00, 14'h0000, 1'b0, 32'h0);
      chk(o_seq_abort, 1'b1, "zero start aborts");
      frame(8'h05, 7'h01, 14'h0000, 1'b0, 32'h0);
      seq_chk(1'b1, 7'h05, 1'b0, 1'b0);
      @(posedge i_mclk);
      i_start_action <= 1'b0;
      // range edges: 0 and 99 start, 100 and 127 refused; the top input never counts
      foreach (sel_rin[k]) begin
         frame(8'h00, 7'h00, 14'h0000, 1'b0, 32'h0);
         frame(sel_rin[k], 7'h01, 14'h0000, 1'b0, 32'h0);
         seq_chk(sel_rin[k][6:0] <= 7'd99, sel_rin[k][6:0], 1'b0,
                 sel_rin[k][6:0] > 7'd99);
      end
      frame(8'h00, 7'h00, 14'h0000, 1'b0, 32'h0);
      @(posedge i_mclk);
      i_rin_func <= 32'h0000_0003;
      frame(8'h03, 7'h01, 14'h0000, 1'b0, 32'h0);
      seq_chk(1'b1, 7'h02, 1'b0, 1'b0);
      chk(o_general_inputs, 8'h02, "general inputs");
      chk(o_sys_func, 16'h0008, "system functions");
      @(posedge i_mclk);
      i_rin_func <= 32'h0000_0000;
      // message path avoids reusing a selection input inside the program
      frame(8'h00, 7'h00, 14'h1c05, 1'b1, 32'h0000_0003);
      seq_chk(1'b1, 7'h03, 1'b1, 1'b0);
      chk(o_cmd_strobe, 1'b0, "run is no plain command");
      chk(o_handshake_trigger_echo, 1'b1, "trigger echo");
      frame(8'h00, 7'h00, 14'h1c05, 1'b1, 32'h0000_0004);
      seq_chk(1'b0, 7'h00, 1'b1, 1'b0);
      frame(8'h00, 7'h00, 14'h1c05, 1'b0, 32'h0);
      frame(8'h00, 7'h00, 14'h1c05, 1'b1, 32'h0000_0100);
      seq_chk(1'b0, 7'h00, 1'b1, 1'b1);
      frame(8'h00, 7'h00, 14'h1c05, 1'b0, 32'h0);
      frame(8'h00, 7'h10, 14'h1c05, 1'b1, 32'h0000_0003);
      seq_chk(1'b0, 7'h00, 1'b1, 1'b0);
      frame(8'h00, 7'h00, 14'h0000, 1'b0, 32'h0);
      frame(8'h00, 7'h00, 14'h0142, 1'b1, 32'h1234_5678);
      chk(o_cmd_strobe, 1'b1, "command strobe");
      chk(o_cmd_code, 14'h0142, "command code");
      chk(o_cmd_arg, 32'h1234_5678, "command argument");
      frame(8'h00, 7'h00, 14'h0142, 1'b0, 32'h0);
      chk(o_cmd_strobe, 1'b0, "strobe is one pulse");
      frame(8'h02, 7'h11, 14'h0000, 1'b0, 32'h0);
      seq_chk(1'b0, 7'h00, 1'b0, 1'b0);
      chk(o_seq_abort, 1'b1, "abort pulse");
      @(posedge i_mclk);
      i_homing_type <= 4'ha;
      foreach (mv_ctl[k]) begin
         frame(8'h00, mv_ctl[k], 14'h0000, 1'b0, 32'h0);
         chk({o_brake_release, o_motor_current_on, o_motion_stop, o_home_request,
              o_move_neg, o_move_pos}, mv_exp[k], "motion bits");
      end
      chk(o_homing_type, 4'ha, "homing type");
      print_verdict();
   end

   // whole run is about 130 cycles, so this only trips on a hang
   initial begin
      repeat (3000) @(posedge i_mclk);
      n_errors++;
      print_verdict();
   end
endmodule : pdosq_core_tb_top
